// ### bench/exception_state_and_vector_base_tb.sv
// Self-checking bench for the exception state and vector base block.
// Assumes the default build: one tick timer, security and debug present,
// 32 interrupts, and a single-slave AHB-Lite bus with hready = hreadyout.
`timescale 1ns/1ps
`default_nettype none

module exception_state_and_vector_base_tb;
  import exc_ctl_pkg::*;

  // Clock, reset and bus
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  wire logic hready;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [31:0] hrdata;
  logic access_nonsecure = 1'b0;
  // Core side
  logic preempt_indication = 1'b0;
  logic external_pending_indication = 1'b0;
  logic [VEC_W-1:0] pending_vector_number = 9'h000;
  logic [VEC_W-1:0] active_vector_number = 9'h000;
  logic [1:0] tick_fire = 2'h0;
  logic [1:0] tick_taken = 2'h0;
  logic [1:0] deferred_taken = 2'h0;
  wire logic [1:0] tick_pending;
  wire logic [1:0] deferred_pending;
  wire logic tick_target_nonsecure;
  wire logic [31:0] secure_vector_base_copy;
  wire logic [31:0] nonsecure_vector_base_copy;
  wire logic irq;
  int err_total = 0;
  int tests_run = 0;
  logic [31:0] scratch;

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;

  exception_state_and_vector_base #(
    .NUM_TICK_TIMERS(1),
    .SECURITY_EXT(1'b1),
    .DEBUG_EXT(1'b1),
    .NUM_IRQ(32)
  ) exception_state_and_vector_base_inst (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .access_nonsecure(access_nonsecure), .preempt_indication(preempt_indication),
    .external_pending_indication(external_pending_indication),
    .pending_vector_number(pending_vector_number),
    .active_vector_number(active_vector_number), .tick_fire(tick_fire),
    .tick_taken(tick_taken), .deferred_taken(deferred_taken),
    .tick_pending(tick_pending), .deferred_pending(deferred_pending),
    .tick_target_nonsecure(tick_target_nonsecure),
    .secure_vector_base_copy(secure_vector_base_copy),
    .nonsecure_vector_base_copy(nonsecure_vector_base_copy), .irq(irq)
  );

  // Free-running 50 MHz clock
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------------
  // Closing report and comparisons
  // ----------------------------------------------------------------------
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Wait on ready under a bound; a hung slave ends the run
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      err_total++;
      report_and_stop();
    end
  endtask : wait_ready

  // ----------------------------------------------------------------------
  // Bus cycles: called just after a rising edge, return just after one
  // ----------------------------------------------------------------------
  task automatic bus(input logic wr_en, input logic [11:0] off, input logic [31:0] wd,
                     input logic ns, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h00000, off};
    hwrite <= wr_en;
    access_nonsecure <= ns;
    wait_ready();
    // Select only matters in the address phase; dropping it here keeps a
    // following call from touching it twice in one time step
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : bus

  task automatic wr(input logic [11:0] off, input logic [31:0] wd, input logic ns);
    bus(1'b1, off, wd, ns, scratch);
  endtask : wr

  task automatic rd_chk(input logic [11:0] off, input logic ns, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, off, 32'h0000_0000, ns, v);
    chk(v, exp);
  endtask : rd_chk

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : idle

  // One-cycle core pulse, returns once its effect is visible
  task automatic pulse(input int which, input logic [1:0] v);
    if (which == 0) tick_fire <= v;
    if (which == 1) tick_taken <= v;
    if (which == 2) deferred_taken <= v;
    @(posedge sys_clk);
    tick_fire <= 2'h0;
    tick_taken <= 2'h0;
    deferred_taken <= 2'h0;
    @(posedge sys_clk);
  endtask : pulse

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    // Reset state of registers and outputs
    rd_chk(INTR_CTL_STATE_OFF, 1'b0, 32'h0);
    rd_chk(VECTOR_BASE_OFF, 1'b0, 32'h0);
    rd_chk(EVENT_MASK_OFF, 1'b0, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // no write here sets and clears one exception together
    wr(INTR_CTL_STATE_OFF, 32'h0400_0000, 1'b0);
    idle(1);
    chk({30'h0, tick_pending}, 32'h1);
    wr(INTR_CTL_STATE_OFF, 32'h0000_0000, 1'b0);
    rd_chk(INTR_CTL_STATE_OFF, 1'b0, 32'h0400_0000);
    rd_chk(INTR_CTL_STATE_OFF, 1'b1, 32'h0);
    wr(INTR_CTL_STATE_OFF, 32'h0200_0000, 1'b1);
    idle(1);
    chk({30'h0, tick_pending}, 32'h1);
    wr(INTR_CTL_STATE_OFF, 32'h0200_0000, 1'b0);
    idle(1);
    chk({30'h0, tick_pending}, 32'h0);
    rd_chk(INTR_CTL_STATE_OFF, 1'b0, 32'h0);
    wr(INTR_CTL_STATE_OFF, 32'h0400_0000, 1'b1);
    idle(1);
    chk({30'h0, tick_pending}, 32'h0);
    wr(INTR_CTL_STATE_OFF, 32'h0100_0000, 1'b1);
    idle(1);
    chk({31'h0, tick_target_nonsecure}, 32'h0);
    wr(INTR_CTL_STATE_OFF, 32'h0100_0000, 1'b0);
    idle(1);
    chk({31'h0, tick_target_nonsecure}, 32'h1);
    rd_chk(INTR_CTL_STATE_OFF, 1'b0, 32'h0100_0000);
    rd_chk(INTR_CTL_STATE_OFF, 1'b1, 32'h0);
    wr(INTR_CTL_STATE_OFF, 32'h0400_0000, 1'b1);
    rd_chk(INTR_CTL_STATE_OFF, 1'b1, 32'h0400_0000);
    wr(INTR_CTL_STATE_OFF, 32'h0200_0000, 1'b1);
    idle(1);
    chk({30'h0, tick_pending}, 32'h0);
    wr(INTR_CTL_STATE_OFF, 32'h0000_0000, 1'b0);
    idle(1);
    chk({31'h0, tick_target_nonsecure}, 32'h0);
    wr(INTR_CTL_STATE_OFF, 32'h1000_0000, 1'b0);
    rd_chk(INTR_CTL_STATE_OFF, 1'b1, 32'h0);
    wr(INTR_CTL_STATE_OFF, 32'h1000_0000, 1'b1);
    rd_chk(INTR_CTL_STATE_OFF, 1'b1, 32'h1000_0000);
    chk({30'h0, deferred_pending}, 32'h3);
    wr(INTR_CTL_STATE_OFF, 32'h0800_0000, 1'b0);
    idle(1);
    chk({30'h0, deferred_pending}, 32'h2);
    // Core pulses: any timer pends copy 0, entry clears it
    pulse(0, 2'h2);
    chk({30'h0, tick_pending}, 32'h1);
    pulse(1, 2'h1);
    chk({30'h0, tick_pending}, 32'h0);
    pulse(2, 2'h2);
    chk({30'h0, deferred_pending}, 32'h0);
    preempt_indication <= 1'b1;
    external_pending_indication <= 1'b1;
    pending_vector_number <= 9'h1ab;
    active_vector_number <= 9'h0f3;
    wr(INTR_CTL_STATE_OFF, 32'h00ff_ffff, 1'b0);
    rd_chk(INTR_CTL_STATE_OFF, 1'b0, 32'h00da_b0f3);
    preempt_indication <= 1'b0;
    external_pending_indication <= 1'b0;
    pending_vector_number <= 9'h000;
    active_vector_number <= 9'h000;
    rd_chk(INTR_CTL_STATE_OFF, 1'b0, 32'h0);
    wr(VECTOR_BASE_OFF, 32'hffff_ffff, 1'b0);
    rd_chk(VECTOR_BASE_OFF, 1'b0, 32'hffff_ff80);
    wr(VECTOR_BASE_OFF, 32'h1234_5601, 1'b1);
    rd_chk(VECTOR_BASE_OFF, 1'b1, 32'h1234_5600);
    rd_chk(VECTOR_BASE_OFF, 1'b0, 32'hffff_ff80);
    chk(secure_vector_base_copy, 32'hffff_ff80);
    chk(nonsecure_vector_base_copy, 32'h1234_5600);
    // Event status, mask and interrupt; earlier events are flushed first
    bus(1'b0, EVENT_STATUS_OFF, 32'h0, 1'b0, scratch);
    rd_chk(EVENT_STATUS_OFF, 1'b0, 32'h0);
    wr(EVENT_MASK_OFF, 32'h0000_0007, 1'b0);
    rd_chk(EVENT_MASK_OFF, 1'b0, 32'h0000_0007);
    chk({31'h0, irq}, 32'h0);
    pulse(0, 2'h1);
    idle(2);
    chk({31'h0, irq}, 32'h1);
    wr(EVENT_MASK_OFF, 32'h0000_0006, 1'b0);
    idle(1);
    chk({31'h0, irq}, 32'h0);
    rd_chk(EVENT_STATUS_OFF, 1'b0, 32'h0000_0001);
    rd_chk(EVENT_STATUS_OFF, 1'b0, 32'h0);
    wr(VECTOR_BASE_OFF, 32'h0000_0100, 1'b0);
    idle(2);
    chk({31'h0, irq}, 32'h1);
    rd_chk(EVENT_STATUS_OFF, 1'b0, 32'h0000_0004);
    idle(1);
    chk({31'h0, irq}, 32'h0);
    // Unmapped offsets read zero and ignore writes
    wr(12'h00c, 32'hdead_beef, 1'b0);
    rd_chk(12'h00c, 1'b0, 32'h0);
    rd_chk(12'h000, 1'b0, 32'h0);
    report_and_stop();
  end

endmodule : exception_state_and_vector_base_tb

`default_nettype wire

// ### hw/exc_ctl_pkg.sv
// Package for the exception state and vector base block: register offsets,
// field positions, reset values and event bit positions.
// Assumes a 32-bit AHB-Lite register slave decoding the low 12 address bits.
package exc_ctl_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses within the block)
  // ----------------------------------------------------------------------
  localparam logic [11:0] INTR_CTL_STATE_OFF = 12'h004;
  localparam logic [11:0] VECTOR_BASE_OFF = 12'h008;
  localparam logic [11:0] EVENT_STATUS_OFF = 12'h010;
  localparam logic [11:0] EVENT_MASK_OFF = 12'h014;
  localparam int ADDR_W = 12;

  // ----------------------------------------------------------------------
  // Control and state register fields
  // ----------------------------------------------------------------------
  localparam int DEFER_SET_BIT = 28;
  localparam int DEFER_CLR_BIT = 27;
  localparam int TICK_SET_BIT = 26;
  localparam int TICK_CLR_BIT = 25;
  localparam int TICK_TARGET_BIT = 24;
  localparam int PREEMPT_BIT = 23;
  localparam int EXT_PEND_BIT = 22;
  localparam int PEND_VEC_LSB = 12;
  localparam int ACT_VEC_LSB = 0;
  localparam int VEC_W = 9;

  // ----------------------------------------------------------------------
  // Vector base field and table size limits
  // ----------------------------------------------------------------------
  localparam int BASE_LSB_SMALL = 7;
  localparam int BASE_LSB_MID = 8;
  localparam int BASE_LSB_LARGE = 9;
  localparam int IRQ_LIMIT_SMALL = 47;
  localparam int IRQ_LIMIT_MID = 111;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] VECTOR_BASE_RESET = 32'h0000_0000;
  localparam logic TICK_TARGET_RESET = 1'b0;
  localparam logic [1:0] PENDING_RESET = 2'h0;

  // ----------------------------------------------------------------------
  // Event status and mask layout
  // ----------------------------------------------------------------------
  localparam int EV_TICK = 0;
  localparam int EV_DEFER = 1;
  localparam int EV_BASE = 2;
  localparam int EV_W = 3;
  localparam logic [EV_W-1:0] EVENT_RESET = 3'h0;

  // Bank indices of the pending copies
  localparam int BANK_S = 0;
  localparam int BANK_NS = 1;

endpackage : exc_ctl_pkg

// ### hw/exception_state_and_vector_base.sv
// Exception control and state register, banked vector table base and an
// event status/mask pair, all behind an AHB-Lite slave with zero-wait writes and one-wait reads.
// Assumes the core supplies preempt, pending and active vector state, the
// security of each access, and pulses when tick/deferred exceptions occur.
//
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module exception_state_and_vector_base #(
  parameter int NUM_TICK_TIMERS = 1,
  parameter bit SECURITY_EXT = 1'b1,
  parameter bit DEBUG_EXT = 1'b1,
  parameter int NUM_IRQ = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Security of the access in its address phase
  input wire logic access_nonsecure,
  // Core exception state
  input wire logic preempt_indication,
  input wire logic external_pending_indication,
  input wire logic [exc_ctl_pkg::VEC_W-1:0] pending_vector_number,
  input wire logic [exc_ctl_pkg::VEC_W-1:0] active_vector_number,
  // Hardware pend and acknowledge pulses, index 0 secure, 1 non-secure
  input wire logic [1:0] tick_fire,
  input wire logic [1:0] tick_taken,
  input wire logic [1:0] deferred_taken,
  // Exception state to the core
  output logic [1:0] tick_pending,
  output logic [1:0] deferred_pending,
  output logic tick_target_nonsecure,
  output logic [31:0] secure_vector_base_copy,
  output logic [31:0] nonsecure_vector_base_copy,
  // Interrupt
  output logic irq
);
  import exc_ctl_pkg::*;

  // ----------------------------------------------------------------------
  // Vector base field width
  // ----------------------------------------------------------------------
  // Mask of implemented table base bits, bigger tables need coarser alignment
  function automatic logic [31:0] base_mask(input int irqs);
    logic [31:0] m;
    m = '1;
    if (irqs <= IRQ_LIMIT_SMALL) begin
      m = m << BASE_LSB_SMALL;
    end else if (irqs <= IRQ_LIMIT_MID) begin
      m = m << BASE_LSB_MID;
    end else begin
      m = m << BASE_LSB_LARGE;
    end
    return m;
  endfunction : base_mask

  localparam logic [31:0] BASE_MASK = base_mask(NUM_IRQ);

  // ----------------------------------------------------------------------
  // Bus phase tracking
  // ----------------------------------------------------------------------
  logic ph_valid;
  logic ph_write;
  logic ph_ns;
  logic [ADDR_W-1:0] ph_addr;
  logic rd_done;
  logic [EV_W-1:0] ev_status;
  logic [EV_W-1:0] ev_mask;
  logic addr_take;

  // Reads spend one wait cycle so hrdata comes from a flop and sees writes
  assign hreadyout = !(ph_valid && !ph_write) || rd_done;
  assign hresp = 1'b0;
  assign addr_take = hsel && htrans[1] && hready;

  // Address phase capture
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_ns <= 1'b0;
      ph_addr <= '0;
    end else if (hready) begin
      ph_valid <= addr_take;
      ph_write <= hwrite;
      ph_ns <= access_nonsecure && SECURITY_EXT;
      ph_addr <= haddr[ADDR_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Access qualification
  // ----------------------------------------------------------------------
  logic wr_ics;
  logic wr_base;
  logic wr_mask;
  logic rd_cap;
  logic bank;
  logic tick_ok;
  logic tick_idx;
  logic target_ok;

  assign wr_ics = ph_valid && ph_write && ph_addr == INTR_CTL_STATE_OFF;
  assign wr_base = ph_valid && ph_write && ph_addr == VECTOR_BASE_OFF;
  assign wr_mask = ph_valid && ph_write && ph_addr == EVENT_MASK_OFF;
  assign rd_cap = ph_valid && !ph_write && !rd_done;
  assign bank = ph_ns;

  // Which tick copy the access reaches, and whether it reaches one at all
  always_comb begin
    tick_ok = 1'b0;
    tick_idx = BANK_S[0];
    target_ok = 1'b0;
    if (NUM_TICK_TIMERS == 2) begin
      tick_ok = 1'b1;
      tick_idx = bank;
    // non-secure blocked while timer is secure
    end else if (NUM_TICK_TIMERS == 1) begin
      tick_ok = !bank || tick_target_nonsecure;
      tick_idx = BANK_S[0];
    end
    // target bit only from secure, single timer, security present
    target_ok = SECURITY_EXT && NUM_TICK_TIMERS == 1 && !bank;
  end

  // ----------------------------------------------------------------------
  // Software set and clear requests
  // ----------------------------------------------------------------------
  logic tick_sw_set;
  logic tick_sw_clr;
  logic [1:0] tick_hw_set;
  logic defer_sw_set;
  logic defer_sw_clr;
  logic [1:0] next_tick_pending;
  logic [1:0] next_deferred_pending;

  assign tick_sw_set = wr_ics && tick_ok && hwdata[TICK_SET_BIT];
  assign tick_sw_clr = wr_ics && tick_ok && hwdata[TICK_CLR_BIT];
  assign defer_sw_set = wr_ics && hwdata[DEFER_SET_BIT];
  assign defer_sw_clr = wr_ics && hwdata[DEFER_CLR_BIT];
  // Single timer drives copy 0 from whichever fire line is in use
  assign tick_hw_set = (NUM_TICK_TIMERS == 2) ? tick_fire :
                       (NUM_TICK_TIMERS == 1) ? {1'b0, |tick_fire} : 2'b00;

  // Pending next values; any set beats a clear in the same cycle
  always_comb begin
    next_tick_pending = tick_pending;
    next_deferred_pending = deferred_pending;
    for (int i = 0; i < 2; i++) begin
      // clear by write or by exception entry
      if ((tick_sw_clr && tick_idx == i[0]) || tick_taken[i]) begin
        next_tick_pending[i] = 1'b0;
      end
      // set by write or timer, set wins
      if ((tick_sw_set && tick_idx == i[0]) || tick_hw_set[i]) begin
        next_tick_pending[i] = 1'b1;
      end
      // deferred clear then set, banked by access
      if ((defer_sw_clr && bank == i[0]) || deferred_taken[i]) begin
        next_deferred_pending[i] = 1'b0;
      end
      if (defer_sw_set && bank == i[0]) begin
        next_deferred_pending[i] = 1'b1;
      end
    end
    if (NUM_TICK_TIMERS < 2) begin
      next_tick_pending[BANK_NS] = 1'b0;
    end
    if (NUM_TICK_TIMERS == 0) begin
      next_tick_pending[BANK_S] = 1'b0;
    end
    if (!SECURITY_EXT) begin
      next_deferred_pending[BANK_NS] = 1'b0;
    end
  end

  // Pending state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_pending <= PENDING_RESET;
      deferred_pending <= PENDING_RESET;
    end else begin
      tick_pending <= next_tick_pending;
      deferred_pending <= next_deferred_pending;
    end
  end

  // tick target bit, secure writes only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_target_nonsecure <= TICK_TARGET_RESET;
    end else if (wr_ics && target_ok) begin
      tick_target_nonsecure <= hwdata[TICK_TARGET_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Vector table base copies
  // ----------------------------------------------------------------------
  // each security state writes its own copy
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      secure_vector_base_copy <= VECTOR_BASE_RESET;
      nonsecure_vector_base_copy <= VECTOR_BASE_RESET;
    end else if (wr_base) begin
      // low bits below the field are never stored
      if (bank) begin
        nonsecure_vector_base_copy <= hwdata & BASE_MASK;
      end else begin
        secure_vector_base_copy <= hwdata & BASE_MASK;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [31:0] rd_value;

  // Fields assembled per bank; everything not listed reads zero
  always_comb begin
    rd_value = '0;
    case (ph_addr)
      INTR_CTL_STATE_OFF: begin
        rd_value[DEFER_SET_BIT] = deferred_pending[bank];
        // tick pending visible only where accessible
        rd_value[TICK_SET_BIT] = tick_ok && tick_pending[tick_idx];
        rd_value[TICK_TARGET_BIT] = target_ok && tick_target_nonsecure;
        rd_value[PREEMPT_BIT] = DEBUG_EXT && preempt_indication;
        rd_value[EXT_PEND_BIT] = DEBUG_EXT && external_pending_indication;
        // pending vector straight from the core, active vector only with debug
        rd_value[PEND_VEC_LSB +: VEC_W] = pending_vector_number;
        rd_value[ACT_VEC_LSB +: VEC_W] = DEBUG_EXT ? active_vector_number : '0;
      end
      // base of the accessing bank, low bits zero
      VECTOR_BASE_OFF: begin
        rd_value = bank ? nonsecure_vector_base_copy : secure_vector_base_copy;
      end
      EVENT_STATUS_OFF: begin
        rd_value[EV_W-1:0] = ev_status;
      end
      EVENT_MASK_OFF: begin
        rd_value[EV_W-1:0] = ev_mask;
      end
      default: begin
        rd_value = '0;
      end
    endcase
  end

  // Read data flop and wait-state tracking
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hrdata <= '0;
      rd_done <= 1'b0;
    end else begin
      if (rd_cap) begin
        hrdata <= rd_value;
      end
      if (hready) begin
        rd_done <= 1'b0;
      end else if (rd_cap) begin
        rd_done <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Event status, mask and interrupt
  // ----------------------------------------------------------------------
  logic [EV_W-1:0] ev_set;
  logic base_write_ev;

  assign base_write_ev = wr_base;
  assign ev_set[EV_TICK] = |(next_tick_pending & ~tick_pending);
  assign ev_set[EV_DEFER] = |(next_deferred_pending & ~deferred_pending);
  assign ev_set[EV_BASE] = base_write_ev;

  // Sticky status, cleared by a read of it; a new event outlives the read
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ev_status <= EVENT_RESET;
    end else if (rd_cap && ph_addr == EVENT_STATUS_OFF) begin
      ev_status <= ev_set;
    end else begin
      ev_status <= ev_status | ev_set;
    end
  end

  // Mask register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ev_mask <= EVENT_RESET;
    end else if (wr_mask) begin
      ev_mask <= hwdata[EV_W-1:0];
    end
  end

  assign irq = |(ev_status & ev_mask);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_tick_set_pends: assert property (
    @(posedge sys_clk) disable iff (rst)
    tick_sw_set |=> tick_pending[$past(tick_idx)])
    else $error("tick set-pending write did not pend");

  chk_tick_clear_pend: assert property (
    @(posedge sys_clk) disable iff (rst)
    tick_sw_clr && !tick_sw_set && !(|tick_hw_set) |=> !tick_pending[$past(tick_idx)])
    else $error("tick clear-pending write did not clear");

  chk_tick_ns_block: assert property (
    @(posedge sys_clk) disable iff (rst)
    wr_ics && bank && NUM_TICK_TIMERS == 1 && !tick_target_nonsecure && !(|tick_fire)
      && !(|tick_taken) |=> tick_pending == $past(tick_pending))
    else $error("non-secure write reached secure tick timer");

  chk_target_write: assert property (
    @(posedge sys_clk) disable iff (rst)
    wr_ics && target_ok |=> tick_target_nonsecure == $past(hwdata[TICK_TARGET_BIT]))
    else $error("tick target bit not written");

  chk_target_ns_wi: assert property (
    @(posedge sys_clk) disable iff (rst)
    wr_ics && bank |=> $stable(tick_target_nonsecure))
    else $error("tick target changed by non-secure write");

  chk_defer_set_pends: assert property (
    @(posedge sys_clk) disable iff (rst)
    defer_sw_set |=> deferred_pending[$past(bank)])
    else $error("deferred set-pending write did not pend");

  chk_base_low_zero: assert property (
    @(posedge sys_clk) disable iff (rst)
    ((secure_vector_base_copy | nonsecure_vector_base_copy) & ~BASE_MASK) == '0)
    else $error("unimplemented vector base bits set");

  chk_base_bank_select: assert property (
    @(posedge sys_clk) disable iff (rst)
    wr_base && bank |=> nonsecure_vector_base_copy == ($past(hwdata) & BASE_MASK)
      && $stable(secure_vector_base_copy))
    else $error("non-secure base write went to the wrong copy");

  chk_read_preempt: assert property (
    @(posedge sys_clk) disable iff (rst)
    rd_cap && ph_addr == INTR_CTL_STATE_OFF |=>
      hrdata[PREEMPT_BIT] == (DEBUG_EXT && $past(preempt_indication)) && hreadyout)
    else $error("preempt indication read back wrong");

endmodule : exception_state_and_vector_base

`default_nettype wire
